// file: rtl/cpm_pkg.sv
package cpm_pkg;
  // ------------------------------------------------------------
  // Flag bit positions
  // ------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_X = 6;
  localparam int FLG_S = 7;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RST = 8'hd0;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] SP_RST    = 16'h00ff;
  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_PAGE2         = 8'h18;
  localparam logic [7:0] OP_ADD_ACCS      = 8'h1b;
  localparam logic [7:0] OP_ABX           = 8'h3a;
  localparam logic [7:0] OP_SHL_DBL       = 8'h05;
  localparam logic [7:0] OP_NO_OPERATION  = 8'h01;
  localparam logic [7:0] OP_TAP           = 8'h06;
  localparam logic [7:0] OP_STOP          = 8'hcf;
  localparam logic [7:0] OP_RET_INT       = 8'h3b;
  localparam logic [7:0] OP_SEI           = 8'h0f;
  localparam logic [7:0] OP_CLI           = 8'h0e;
  localparam logic [7:0] OP_BR_HIGHER     = 8'h22;
  localparam logic [7:0] OP_BR_CARRY_CLR  = 8'h24;
  localparam logic [7:0] OP_BR_CARRY_SET  = 8'h25;
  localparam logic [7:0] OP_BR_EQUAL      = 8'h27;
  localparam logic [7:0] OP_BR_GE_SIGNED  = 8'h2c;
  localparam logic [7:0] OP_BR_GT_SIGNED  = 8'h2e;
  localparam logic [7:0] OP_BIT_TEST_A    = 8'h85;
  localparam logic [7:0] OP_BIT_TEST_B    = 8'hc5;
  localparam logic [7:0] OP_ADDA          = 8'h8b;
  localparam logic [7:0] OP_ADCA          = 8'h89;
  // ------------------------------------------------------------
  // Cycle counts
  // ------------------------------------------------------------
  localparam logic [3:0] CYC_INH2 = 4'h2;
  localparam logic [3:0] CYC_INH3 = 4'h3;
  localparam logic [3:0] CYC_IMM  = 4'h2;
  localparam logic [3:0] CYC_BR   = 4'h3;
  localparam logic [3:0] CYC_PAGE = 4'h1;
  localparam logic [3:0] CYC_RET_INT = 4'h3;
  typedef enum logic [3:0] {
    CPM_FETCH = 4'b0001,
    CPM_OPER  = 4'b0010,
    CPM_WAIT  = 4'b0100,
    CPM_STOP  = 4'b1000
  } cpm_state_type;
endpackage : cpm_pkg

// file: rtl/cpm_core.sv
`timescale 1ns/1ns
module cpm_core #(
  parameter int ADDR_W = 16                        // Address width
) (
  input  wire logic              i_ref_clk,        // Core clock
  input  wire logic              i_srst,           // Sync reset, high
  input  wire logic [7:0]        i_rdata,          // Memory read data
  input  wire logic              i_nmi_req_n,      // Nonmaskable request, low
  input  wire logic              i_irq_n,          // Maskable request, low
  output logic      [ADDR_W-1:0] o_addr,           // Memory address
  output logic      [7:0]        o_wdata,          // Memory write data
  output logic                   o_wr,             // Memory write strobe
  output logic      [7:0]        o_flags,          // Flags register
  output logic      [15:0]       o_pc,             // Program counter
  output logic      [15:0]       o_acc_d,          // Double accumulator
  output logic      [15:0]       o_first_index,    // First index
  output logic      [15:0]       o_second_index,   // Second index
  output logic      [15:0]       o_stack_pointer,  // Stack pointer
  output logic                   o_stopped,        // Stop taken
  output logic                   o_irq_taken       // Maskable irq accepted
);
  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  // Address and stack arithmetic are built 16 bits wide
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("ADDR_W must be 16");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cpm_pkg::cpm_state_type st_q;
  cpm_pkg::cpm_state_type st_d;
  logic [7:0]             acc_a_q;
  logic [7:0]             acc_a_d;
  logic [7:0]             acc_b_q;
  logic [7:0]             acc_b_d;
  logic [7:0]             flg_q;
  logic [7:0]             flg_d;
  logic [7:0]             op_q;
  logic [7:0]             op_d;
  logic [15:0]            pc_q;
  logic [15:0]            pc_d;
  logic [15:0]            idx1_q;
  logic [15:0]            idx1_d;
  logic [15:0]            idx2_q;
  logic [15:0]            idx2_d;
  logic [15:0]            sp_q;
  logic [15:0]            sp_d;
  logic                   page_q;
  logic                   page_d;
  logic                   stop_q;
  logic                   stop_d;
  logic                   irq_q;
  logic                   irq_d;
  logic                   wr_q;
  logic                   wr_d;
  logic [3:0]             cyc_q;
  logic [3:0]             cyc_d;
  logic [7:0]             wd_q;
  logic [7:0]             wd_d;
  logic [15:0]            ad_q;
  logic [15:0]            ad_d;
  logic [8:0]             sum9;
  logic [4:0]             sum5;
  logic [7:0]             opnd;
  logic [7:0]             res8;
  logic [7:0]             bit_res;
  logic [16:0]            shl;
  logic                   take;

  // Branch condition decode, used by execute through take
  function automatic logic br_cond(input logic [7:0] op, input logic [7:0] f);
    logic nxv;
    nxv = f[cpm_pkg::FLG_N] ^ f[cpm_pkg::FLG_V];
    case (op)
      cpm_pkg::OP_BR_HIGHER:    br_cond = !(f[cpm_pkg::FLG_C] | f[cpm_pkg::FLG_Z]);
      cpm_pkg::OP_BR_CARRY_CLR: br_cond = !f[cpm_pkg::FLG_C];
      cpm_pkg::OP_BR_GE_SIGNED: br_cond = !nxv;
      cpm_pkg::OP_BR_GT_SIGNED: br_cond = !f[cpm_pkg::FLG_Z] && !nxv;
      cpm_pkg::OP_BR_EQUAL:     br_cond = f[cpm_pkg::FLG_Z];
      cpm_pkg::OP_BR_CARRY_SET: br_cond = f[cpm_pkg::FLG_C];
      default:                  br_cond = 1'b0;
    endcase
  endfunction : br_cond

  // Branch opcode decode, shared by fetch, execute and checks
  function automatic logic is_branch(input logic [7:0] op);
    is_branch = (op == cpm_pkg::OP_BR_HIGHER) || (op == cpm_pkg::OP_BR_CARRY_CLR) ||
                (op == cpm_pkg::OP_BR_GE_SIGNED) || (op == cpm_pkg::OP_BR_GT_SIGNED) ||
                (op == cpm_pkg::OP_BR_EQUAL) || (op == cpm_pkg::OP_BR_CARRY_SET);
  endfunction : is_branch

  // ------------------------------------------------------------
  // Datapath helpers
  // ------------------------------------------------------------
  // Adder is shared by all three add forms
  always_comb begin
    opnd = (op_q == cpm_pkg::OP_ADD_ACCS) ? acc_b_q : i_rdata;
    sum9 = {1'b0, acc_a_q} + {1'b0, opnd} +
           {8'h00, (op_q == cpm_pkg::OP_ADCA) & flg_q[cpm_pkg::FLG_C]};
    sum5 = {1'b0, acc_a_q[3:0]} + {1'b0, opnd[3:0]} +
           {4'h0, (op_q == cpm_pkg::OP_ADCA) & flg_q[cpm_pkg::FLG_C]};
    res8 = sum9[7:0];
    // Bit test result is only looked at, never stored
    bit_res = ((op_q == cpm_pkg::OP_BIT_TEST_A) ? acc_a_q : acc_b_q) & i_rdata;
    shl  = {acc_a_q, acc_b_q, 1'b0};
    take = br_cond(op_q, flg_q);
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    flg_d   = flg_q;
    op_d    = op_q;
    pc_d    = pc_q;
    idx1_d  = idx1_q;
    idx2_d  = idx2_q;
    sp_d    = sp_q;
    page_d  = page_q;
    stop_d  = stop_q;
    irq_d   = 1'b0;
    wr_d    = 1'b0;
    cyc_d   = cyc_q;
    wd_d    = wd_q;
    ad_d    = pc_q;
    // Nonmaskable request sets the mask, only hardware may
    if (!i_nmi_req_n) flg_d[cpm_pkg::FLG_X] = 1'b1;
    case (st_q)
      cpm_pkg::CPM_FETCH: begin
        // Maskable request is gated by the interrupt mask
        if (!i_irq_n && !flg_q[cpm_pkg::FLG_I] && !page_q) begin
          irq_d = 1'b1;
          flg_d[cpm_pkg::FLG_I] = 1'b1;
          sp_d = sp_q - 16'h0001;
          wr_d = 1'b1;
          ad_d = sp_q;
          wd_d = pc_q[7:0];
          // The push owns the bus next cycle, so no fetch then
          st_d = cpm_pkg::CPM_WAIT;
        end else begin
          op_d  = i_rdata;
          pc_d  = pc_q + 16'h0001;
          ad_d  = pc_q + 16'h0001;
          if (i_rdata == cpm_pkg::OP_PAGE2 && !page_q) begin
            page_d = 1'b1;
          end else begin
            st_d  = cpm_pkg::CPM_OPER;
            // One fetch cycle spent; remainder counts down
            cyc_d = cpm_pkg::CYC_INH2 - 4'h1;
            if (i_rdata == cpm_pkg::OP_SHL_DBL || i_rdata == cpm_pkg::OP_ABX) begin
              cyc_d = cpm_pkg::CYC_INH3 - 4'h1;
            end
            if (is_branch(i_rdata)) begin
              cyc_d = cpm_pkg::CYC_BR - 4'h1;
            end
            if (i_rdata == cpm_pkg::OP_RET_INT) begin
              cyc_d = cpm_pkg::CYC_RET_INT - 4'h1;
            end
          end
        end
      end
      cpm_pkg::CPM_WAIT: begin
        // Push cycle: stack address and strobe stand on the bus
        st_d = cpm_pkg::CPM_FETCH;
      end
      cpm_pkg::CPM_OPER: begin
        cyc_d = cyc_q - 4'h1;
        if (cyc_q == 4'h1) begin
          st_d = cpm_pkg::CPM_FETCH;
          page_d = 1'b0;
          case (op_q)
            cpm_pkg::OP_ADD_ACCS, cpm_pkg::OP_ADDA, cpm_pkg::OP_ADCA: begin
              acc_a_d = res8;
              flg_d[cpm_pkg::FLG_H] = sum5[4];
              flg_d[cpm_pkg::FLG_C] = sum9[8];
              flg_d[cpm_pkg::FLG_V] = (acc_a_q[7] == opnd[7]) && (res8[7] != acc_a_q[7]);
              flg_d[cpm_pkg::FLG_Z] = (res8 == 8'h00);
              flg_d[cpm_pkg::FLG_N] = res8[7];
              // Immediate forms step over their operand byte
              if (op_q != cpm_pkg::OP_ADD_ACCS) pc_d = pc_q + 16'h0001;
            end
            cpm_pkg::OP_SHL_DBL: begin
              {acc_a_d, acc_b_d} = shl[15:0];
              flg_d[cpm_pkg::FLG_C] = shl[16];
              flg_d[cpm_pkg::FLG_N] = shl[15];
              flg_d[cpm_pkg::FLG_Z] = (shl[15:0] == 16'h0000);
              flg_d[cpm_pkg::FLG_V] = shl[16] ^ shl[15];
            end
            cpm_pkg::OP_BIT_TEST_A, cpm_pkg::OP_BIT_TEST_B: begin
              flg_d[cpm_pkg::FLG_N] = bit_res[7];
              flg_d[cpm_pkg::FLG_Z] = (bit_res == 8'h00);
              flg_d[cpm_pkg::FLG_V] = 1'b0;
              pc_d = pc_q + 16'h0001;
            end
            cpm_pkg::OP_ABX: begin
              // Second page form uses the second index, one cycle more
              if (page_q) idx2_d = idx2_q + {8'h00, acc_b_q};
              else        idx1_d = idx1_q + {8'h00, acc_b_q};
            end
            cpm_pkg::OP_TAP: begin
              // Program may clear the nonmaskable mask but never set it
              flg_d = {acc_a_q[7], flg_q[cpm_pkg::FLG_X] & acc_a_q[6], acc_a_q[5:0]} |
                      {1'b0, ~i_nmi_req_n, 6'h00};
            end
            cpm_pkg::OP_RET_INT: begin
              flg_d = {i_rdata[7], flg_q[cpm_pkg::FLG_X] & i_rdata[6], i_rdata[5:0]} |
                      {1'b0, ~i_nmi_req_n, 6'h00};
              sp_d  = sp_q + 16'h0001;
            end
            cpm_pkg::OP_SEI: flg_d[cpm_pkg::FLG_I] = 1'b1;
            cpm_pkg::OP_CLI: flg_d[cpm_pkg::FLG_I] = 1'b0;
            cpm_pkg::OP_STOP: begin
              // Stop disabled means plain no operation
              if (!flg_q[cpm_pkg::FLG_S]) begin
                st_d = cpm_pkg::CPM_STOP;
                stop_d = 1'b1;
              end
            end
            default: begin
              if (is_branch(op_q)) begin
                pc_d = pc_q + 16'h0001;
                if (take) pc_d = pc_q + 16'h0001 + {{8{i_rdata[7]}}, i_rdata};
              end
            end
          endcase
          ad_d = pc_d;
        end else if (op_q == cpm_pkg::OP_RET_INT) begin
          // Pull reads the byte above the free stack slot
          ad_d = sp_q + 16'h0001;
        end
      end
      cpm_pkg::CPM_STOP: begin
        // Only a request wakes a stopped core
        if (!i_irq_n || !i_nmi_req_n) begin
          st_d = cpm_pkg::CPM_FETCH;
          stop_d = 1'b0;
        end
      end
      default: st_d = cpm_pkg::CPM_FETCH;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q    <= cpm_pkg::CPM_FETCH;
      acc_a_q <= 8'h00;
      acc_b_q <= 8'h00;
      op_q    <= cpm_pkg::OP_NO_OPERATION;
      flg_q   <= cpm_pkg::FLAGS_RST;
      pc_q    <= cpm_pkg::PC_RST;
      sp_q    <= cpm_pkg::SP_RST;
      idx1_q  <= 16'h0000;
      idx2_q  <= 16'h0000;
      page_q  <= 1'b0;
      stop_q  <= 1'b0;
      irq_q   <= 1'b0;
      wr_q    <= 1'b0;
      cyc_q   <= 4'h0;
      wd_q    <= 8'h00;
      ad_q    <= cpm_pkg::PC_RST;
    end else begin
      st_q    <= st_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      op_q    <= op_d;
      flg_q   <= flg_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      idx1_q  <= idx1_d;
      idx2_q  <= idx2_d;
      page_q  <= page_d;
      stop_q  <= stop_d;
      irq_q   <= irq_d;
      wr_q    <= wr_d;
      cyc_q   <= cyc_d;
      wd_q    <= wd_d;
      ad_q    <= ad_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_addr = ad_q;
  assign o_wdata = wd_q;
  assign o_wr = wr_q;
  assign o_flags = flg_q;
  assign o_pc = pc_q;
  assign o_acc_d = {acc_a_q, acc_b_q};
  assign o_first_index = idx1_q;
  assign o_second_index = idx2_q;
  assign o_stack_pointer = sp_q;
  assign o_stopped = stop_q;
  assign o_irq_taken = irq_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_IMASK: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    irq_q |-> !$past(flg_q[cpm_pkg::FLG_I])) else $error("irq taken while masked");
  AST_PUSH: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    irq_q |-> sp_q == $past(sp_q) - 16'h0001) else $error("push did not decrement");
  AST_IRQWR: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    irq_q |-> wr_q && ad_q == $past(sp_q)) else $error("push not strobed at stack");
  AST_XSET: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_nmi_req_n |=> flg_q[cpm_pkg::FLG_X]) else $error("xmask not set");
  AST_XHOLD: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ($past(flg_q[cpm_pkg::FLG_X]) && !flg_q[cpm_pkg::FLG_X]) |->
    ($past(op_q) == cpm_pkg::OP_TAP || $past(op_q) == cpm_pkg::OP_RET_INT)) else $error("xmask cleared");
  AST_STOPS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(stop_q) |-> !$past(flg_q[cpm_pkg::FLG_S])) else $error("stop when disabled");
  AST_SNOP: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 && op_q == cpm_pkg::OP_STOP && flg_q[cpm_pkg::FLG_S])
    |=> !stop_q && st_q == cpm_pkg::CPM_FETCH) else $error("disabled stop not skipped");
  AST_BRFLG: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && is_branch(op_q) && i_nmi_req_n) |=> flg_q == $past(flg_q))
    else $error("branch changed flags");
  AST_BRLEN: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_FETCH && is_branch(i_rdata) && !page_q && (i_irq_n || flg_q[cpm_pkg::FLG_I]))
    |=> st_q == cpm_pkg::CPM_OPER ##2 st_q == cpm_pkg::CPM_FETCH) else $error("branch not 3 cycles");
  AST_PAGE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_FETCH && i_rdata == cpm_pkg::OP_PAGE2 && !page_q && !irq_d)
    |=> st_q == cpm_pkg::CPM_FETCH && page_q) else $error("prefix not taken");
  AST_IDX2LEN: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_FETCH && page_q && i_rdata == cpm_pkg::OP_ABX)
    |=> st_q == cpm_pkg::CPM_OPER ##2 st_q == cpm_pkg::CPM_FETCH) else $error("second index form length");
  AST_PCSEQ: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_FETCH && !irq_d) |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("fetch did not advance");
  AST_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 && op_q == cpm_pkg::OP_ADD_ACCS)
    |=> flg_q[cpm_pkg::FLG_Z] == (acc_a_q == 8'h00)) else $error("zero flag wrong");
  AST_NEG: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 && op_q == cpm_pkg::OP_ADD_ACCS)
    |=> flg_q[cpm_pkg::FLG_N] == acc_a_q[7]) else $error("negative flag wrong");
  AST_HALF: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 && op_q == cpm_pkg::OP_ADD_ACCS)
    |=> flg_q[cpm_pkg::FLG_H] == (({1'b0, $past(acc_a_q[3:0])} + {1'b0, $past(acc_b_q[3:0])}) > 5'h0f))
    else $error("half carry wrong");
  AST_SHLC: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 && op_q == cpm_pkg::OP_SHL_DBL)
    |=> flg_q[cpm_pkg::FLG_C] == $past(acc_a_q[7])) else $error("double shift carry wrong");
  AST_BITV: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cpm_pkg::CPM_OPER && cyc_q == 4'h1 &&
     (op_q == cpm_pkg::OP_BIT_TEST_A || op_q == cpm_pkg::OP_BIT_TEST_B))
    |=> !flg_q[cpm_pkg::FLG_V] && acc_a_q == $past(acc_a_q)) else $error("bit test wrong");
endmodule : cpm_core

// file: tb/cpm_mem_model.sv
`timescale 1ns/1ns
module cpm_mem_model (
  input  wire logic        i_ref_clk, // Core clock
  input  wire logic [15:0] i_addr,    // Byte address
  input  wire logic [7:0]  i_wdata,   // Write data
  input  wire logic        i_wr,      // Write strobe
  output logic      [7:0]  o_rdata    // Read data
);
  logic [7:0] mem [0:255];
  // Same-cycle answer; upper address bits alias to save space
  assign o_rdata = mem[i_addr[7:0]];
  // Stack pushes land at the strobed address
  always @(posedge i_ref_clk) begin
    if (i_wr) begin
      mem[i_addr[7:0]] <= i_wdata;
    end
  end
endmodule : cpm_mem_model

// file: tb/cpu_programming_model_core_bench.sv
`timescale 1ns/1ns
module cpu_programming_model_core_bench;
  logic        ref_clk, srst, nmi_n, irq_n, wr, stopped, irq_taken;
  logic [7:0]  rdata, wdata, flags;
  logic [15:0] addr, pc, acc_d, idx1, idx2, sp;
  logic [7:0]  prog [$];
  int          mismatches, cmp_count, cycles, irq_cnt, wr_cnt, k;

  cpm_core cpm_core_i (.i_ref_clk(ref_clk), .i_srst(srst), .i_rdata(rdata), .i_nmi_req_n(nmi_n),
    .i_irq_n(irq_n), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_flags(flags), .o_pc(pc),
    .o_acc_d(acc_d), .o_first_index(idx1), .o_second_index(idx2), .o_stack_pointer(sp),
    .o_stopped(stopped), .o_irq_taken(irq_taken));
  cpm_mem_model cpm_mem_model_i (.i_ref_clk(ref_clk), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .o_rdata(rdata));

  // ----------------------------------------------------------
  // Clock, watchdog and event counters
  // ----------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (!srst) begin
      irq_cnt += int'(irq_taken);
      wr_cnt  += int'(wr);
    end
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Fill with no-ops so a runaway fetch stays harmless
  task automatic start();
    @(negedge ref_clk);
    srst = 1'b1;
    for (int i = 0; i < 256; i++) cpm_mem_model_i.mem[i] = 8'h01;
    foreach (prog[i]) cpm_mem_model_i.mem[i] = prog[i];
    irq_cnt = 0;
    wr_cnt  = 0;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
  endtask : start

  // Run n cycles, then compare the visible state
  task automatic step(input int n, input logic [15:0] acc, input logic [7:0] flg, input logic [15:0] p);
    repeat (n) @(negedge ref_clk);
    chk(acc_d, acc);
    chk({8'h00, flags}, {8'h00, flg});
    chk(pc, p);
    chk(addr, p);
  endtask : step

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_add();
    prog = {8'h8b, 8'h08, 8'h8b, 8'h08, 8'h8b, 8'h70, 8'h8b, 8'h80, 8'h89, 8'h00};
    start();
    step(2, 16'h0800, 8'hd0, 16'h0002);
    step(2, 16'h1000, 8'hf0, 16'h0004);
    step(2, 16'h8000, 8'hda, 16'h0006);
    step(2, 16'h0000, 8'hd7, 16'h0008);
    step(2, 16'h0100, 8'hd0, 16'h000a);
  endtask : t_add

  task automatic t_shift();
    prog = {8'h18, 8'h3a, 8'h3a, 8'h8b, 8'hc1, 8'h05, 8'h05, 8'h85, 8'hfb, 8'hc5, 8'h00, 8'h1b};
    start();
    step(4, 16'h0000, 8'hd0, 16'h0002);
    step(3, 16'h0000, 8'hd0, 16'h0003);
    chk(idx1, 16'h0000);
    chk(idx2, 16'h0000);
    step(2, 16'hc100, 8'hd8, 16'h0005);
    step(3, 16'h8200, 8'hd9, 16'h0006);
    step(3, 16'h0400, 8'hd3, 16'h0007);
    step(2, 16'h0400, 8'hd5, 16'h0009);
    step(2, 16'h0400, 8'hd5, 16'h000b);
    step(2, 16'h0400, 8'hd0, 16'h000c);
  endtask : t_shift

  task automatic t_branch();
    prog = {8'h24, 8'h02, 8'h01, 8'h01, 8'h8b, 8'h80, 8'h2c, 8'h10, 8'h22, 8'h02, 8'h01, 8'h01,
            8'h8b, 8'h80, 8'h27, 8'h04, 8'h01, 8'h01, 8'h2c, 8'h20, 8'h2e, 8'h10, 8'h25, 8'hfa};
    start();
    step(3, 16'h0000, 8'hd0, 16'h0004);
    step(2, 16'h8000, 8'hd8, 16'h0006);
    step(3, 16'h8000, 8'hd8, 16'h0008);
    step(3, 16'h8000, 8'hd8, 16'h000c);
    step(2, 16'h0000, 8'hd7, 16'h000e);
    step(3, 16'h0000, 8'hd7, 16'h0014);
    step(3, 16'h0000, 8'hd7, 16'h0016);
    step(3, 16'h0000, 8'hd7, 16'h0012);
    step(3, 16'h0000, 8'hd7, 16'h0014);
  endtask : t_branch

  // Request held from reset; only the mask clear lets it in
  task automatic t_irq();
    prog = {8'h01, 8'h01, 8'h01, 8'h0e};
    irq_n = 1'b0;
    start();
    repeat (8) @(negedge ref_clk);
    chk(16'(irq_cnt), 16'h0000);
    for (k = 0; k < 20 && irq_cnt == 0; k++) @(negedge ref_clk);
    irq_n = 1'b1;
    chk(16'(irq_cnt), 16'h0001);
    repeat (4) @(negedge ref_clk);
    chk(sp, 16'h00fe);
    chk(16'(wr_cnt), 16'h0001);
    chk({8'h00, cpm_mem_model_i.mem[8'hff]}, 16'h0004);
  endtask : t_irq

  task automatic t_stop();
    prog = {8'hcf, 8'h01, 8'h06, 8'hcf};
    start();
    repeat (4) @(negedge ref_clk);
    chk(pc, 16'h0002);
    chk({15'h0, stopped}, 16'h0000);
    for (k = 0; k < 20 && stopped !== 1'b1; k++) @(negedge ref_clk);
    chk({15'h0, stopped}, 16'h0001);
    chk({8'h00, flags & 8'hc0}, 16'h0000);
    nmi_n = 1'b0;
    for (k = 0; k < 10 && flags[cpm_pkg::FLG_X] !== 1'b1; k++) @(negedge ref_clk);
    nmi_n = 1'b1;
    chk({15'h0, flags[cpm_pkg::FLG_X]}, 16'h0001);
    chk({15'h0, stopped}, 16'h0000);
  endtask : t_stop

  task automatic give_verdict();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  initial begin
    srst       = 1'b1;
    nmi_n      = 1'b1;
    irq_n      = 1'b1;
    mismatches = 0;
    cmp_count  = 0;
    cycles     = 0;
    t_add();
    t_shift();
    t_branch();
    t_irq();
    t_stop();
    give_verdict();
  end
endmodule : cpu_programming_model_core_bench
